//--- verilog/dlm_defines.svh
// How it works
// - Read latency sums column, additive, parity latencies
// - Write latency sums write CAS, additive, parity latencies
// - Additive latency delays write data too
// - Eight beats for field 00, or 01 with select high
// - Field 01 with select low chops to four
// - Field 10 always chops to four beats
// - Command latency mode leaves termination timing alone
// - One mask input per byte lane
// - Mask sampled on same edge as data
// - Mask pin ignored during read bursts
// - Byte-wide termination strobe mode disables masking
// - Inversion mode turns pin into inversion flag when DW is 16 or less
`ifndef DLM_DEFINES_SVH
`define DLM_DEFINES_SVH

// Register offsets
`define DLM_OFS_MODE0   8'h00
`define DLM_OFS_MODE1   8'h04
`define DLM_OFS_MODE5   8'h08
`define DLM_OFS_STATUS  8'h0c

// Field positions and widths
`define DLM_BL_LSB      0
`define DLM_BL_W        2
`define DLM_COL_LAT_LSB    3
`define DLM_WR_CAS_LSB     8
`define DLM_LATF_W         5
`define DLM_ADD_LAT_LSB    3
`define DLM_ADD_LAT_W      2
`define DLM_TDQS_BIT       11
`define DLM_CAL_LSB        12
`define DLM_CAL_W          3
`define DLM_PAR_LAT_LSB    0
`define DLM_PAR_LAT_W      3
`define DLM_DBI_BIT        11
`define DLM_ST_RD_LAT_LSB  0
`define DLM_ST_WR_LAT_LSB  8
`define DLM_ST_BUSY_BIT 16

// Reset values
`define DLM_RST_MODE0   32'h0000_0958
`define DLM_RST_MODE1   32'h0000_0000
`define DLM_RST_MODE5   32'h0000_0000

// Additive latency codes
`define DLM_ADD_LAT_ZERO   2'h0
`define DLM_ADD_LAT_M1     2'h1
`define DLM_ADD_LAT_M2     2'h2

// Burst counts and widths
`define DLM_BEATS_FULL  3'h7
`define DLM_BEATS_CHOP  3'h3
`define DLM_LAT_W       7
`define DLM_COL_W       6

`endif

//--- verilog/dlm_pkg.sv
`include "dlm_defines.svh"
package dlm_pkg;

  typedef enum logic [1:0] {
    DLM_BL_FIXED8  = 2'b00,
    DLM_BL_PER_CMD = 2'b01,
    DLM_BL_FIXED4  = 2'b10
  } dlm_bl_mode_t;

  typedef enum logic [1:0] {
    DLM_ST_IDLE  = 2'b00,
    DLM_ST_READ  = 2'b01,
    DLM_ST_WRITE = 2'b10
  } dlm_state_t;

  typedef struct packed {
    logic                    chop;
    logic [`DLM_COL_W-1:0]   col;
  } dlm_cmd_t;

  typedef struct packed {
    logic [`DLM_LAT_W-1:0]   rd_lat;
    logic [`DLM_LAT_W-1:0]   wr_lat;
    logic [`DLM_CAL_W-1:0]   cal;
    logic [`DLM_BL_W-1:0]    bl;
    logic                    tdqs_en;
    logic                    dbi_en;
  } dlm_cfg_t;

endpackage : dlm_pkg

//--- verilog/dlm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dlm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // Two-stage level synchroniser; only the second stage is read
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out  <= meta_q;
  end

endmodule : dlm_sync
`default_nettype wire

//--- verilog/dlm_sched.sv
`timescale 1ns/10ps
`default_nettype none
module dlm_sched #(
  parameter int DEPTH = 128,
  parameter int PW    = 8,
  parameter int IW    = 7
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          ins_in,
  input  wire logic [IW-1:0] idx_in,
  input  wire logic [PW-1:0] pay_in,
  output logic               pop_out,
  output logic      [PW-1:0] pay_out
);

  logic [DEPTH-1:0]         vld_q;
  logic [PW-1:0]            pay_q [DEPTH];

  // Slot k means k+1 edges until the burst starts
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (ins_in && (idx_in == IW'(i))) begin
        vld_q[i] <= 1'b1;
        pay_q[i] <= pay_in;
      end else if (i == DEPTH - 1) begin
        vld_q[i] <= 1'b0;
        pay_q[i] <= '0;
      end else begin
        vld_q[i] <= vld_q[i+1];
        pay_q[i] <= pay_q[i+1];
      end
    end
    if (rst_in) begin
      vld_q <= '0;
    end
  end

  assign pop_out = vld_q[0];
  assign pay_out = pay_q[0];

endmodule : dlm_sched
`default_nettype wire

//--- verilog/dlm_top.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dlm_defines.svh"
module dlm_top #(
  parameter int DW    = 16,
  parameter int DEPTH = 64,
  parameter int SLOTS = 128
) (
  input  wire logic                    clock_in,
  input  wire logic                    sys_rst_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [31:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [31:0]             reg_rdata_out,
  input  wire logic                    link_clk_in,
  input  wire logic                    link_cs_n_in,
  input  wire logic                    link_cmd_write_in,
  input  wire logic                    link_burst_select_bit_in,
  input  wire logic [`DLM_COL_W-1:0]   link_col_in,
  input  wire logic [DW-1:0]           link_dq_in,
  input  wire logic [DW/8-1:0]         link_write_mask_pin_in,
  input  wire logic                    link_on_die_termination_in,
  output logic      [DW-1:0]           link_dq_out,
  output logic                         link_dq_oe_out,
  output logic                         link_rd_valid_out,
  output logic                         link_on_die_termination_out
);
  import dlm_pkg::*;

  localparam int NL = DW / 8;
  localparam int PW = $bits(dlm_cmd_t);
  localparam int LW = `DLM_LAT_W;

  ////////////////////////////////////////////////////////////////////////
  // Core domain: mode registers

  logic [31:0]              mode0_q;
  logic [31:0]              mode1_q;
  logic [31:0]              mode5_q;
  logic [31:0]              rdata_d;
  logic                     busy_core;
  dlm_cfg_t                 cfg_d;
  dlm_cfg_t                 cfg_q;
  logic [LW-1:0]            col_lat_v;
  logic [LW-1:0]            wcas_lat_v;
  logic [LW-1:0]            add_lat_v;
  logic [LW-1:0]            par_lat_v;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mode0_q <= `DLM_RST_MODE0;
      mode1_q <= `DLM_RST_MODE1;
      mode5_q <= `DLM_RST_MODE5;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `DLM_OFS_MODE0: begin
          mode0_q <= reg_wdata_in;
        end
        `DLM_OFS_MODE1: begin
          mode1_q <= reg_wdata_in;
        end
        `DLM_OFS_MODE5: begin
          mode5_q <= reg_wdata_in;
        end
        default: begin
          mode0_q <= mode0_q;
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_addr_in)
      `DLM_OFS_MODE0: begin
        rdata_d = mode0_q;
      end
      `DLM_OFS_MODE1: begin
        rdata_d = mode1_q;
      end
      `DLM_OFS_MODE5: begin
        rdata_d = mode5_q;
      end
      `DLM_OFS_STATUS: begin
        rdata_d[`DLM_ST_RD_LAT_LSB +: LW] = cfg_q.rd_lat;
        rdata_d[`DLM_ST_WR_LAT_LSB +: LW] = cfg_q.wr_lat;
        rdata_d[`DLM_ST_BUSY_BIT]     = busy_core;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core domain: latency arithmetic

  always_comb begin
    col_lat_v  = LW'(mode0_q[`DLM_COL_LAT_LSB +: `DLM_LATF_W]);
    wcas_lat_v = LW'(mode0_q[`DLM_WR_CAS_LSB +: `DLM_LATF_W]);
    par_lat_v  = LW'(mode5_q[`DLM_PAR_LAT_LSB +: `DLM_PAR_LAT_W]);
    case (mode1_q[`DLM_ADD_LAT_LSB +: `DLM_ADD_LAT_W])
      `DLM_ADD_LAT_M1: begin
        add_lat_v = col_lat_v - LW'(1);
      end
      `DLM_ADD_LAT_M2: begin
        add_lat_v = col_lat_v - LW'(2);
      end
      default: begin
        add_lat_v = '0;
      end
    endcase
    cfg_d.rd_lat  = col_lat_v + add_lat_v + par_lat_v;
    cfg_d.wr_lat  = wcas_lat_v + add_lat_v + par_lat_v;
    cfg_d.cal     = mode1_q[`DLM_CAL_LSB +: `DLM_CAL_W];
    cfg_d.bl      = mode0_q[`DLM_BL_LSB +: `DLM_BL_W];
    cfg_d.tdqs_en = mode1_q[`DLM_TDQS_BIT];
    cfg_d.dbi_en  = mode5_q[`DLM_DBI_BIT];
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossings; mode changes are made only while the link is idle

  logic                     lrst;
  logic                     busy_q;
  dlm_cfg_t                 lcfg;

  dlm_sync #(.W(1)) u_rst_sync (
    .clk_in (link_clk_in),
    .d_in   (sys_rst_in),
    .q_out  (lrst)
  );

  dlm_sync #(.W($bits(dlm_cfg_t))) u_cfg_sync (
    .clk_in (link_clk_in),
    .d_in   (cfg_q),
    .q_out  (lcfg)
  );

  dlm_sync #(.W(1)) u_busy_sync (
    .clk_in (clock_in),
    .d_in   (busy_q),
    .q_out  (busy_core)
  );

  ////////////////////////////////////////////////////////////////////////
  // Link domain: command capture with chip-select latency

  logic [7:0]               cs_hist_q;
  logic                     take;
  logic                     chop;
  dlm_cmd_t                 cmd;
  logic [LW-1:0]            rd_idx;
  logic [LW-1:0]            wr_idx;

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      cs_hist_q <= 8'h00;
    end else begin
      cs_hist_q <= {cs_hist_q[6:0], ~link_cs_n_in};
    end
  end

  always_comb begin
    if (lcfg.cal == '0) begin
      take = ~link_cs_n_in;
    end else begin
      take = cs_hist_q[lcfg.cal - `DLM_CAL_W'(1)];
    end
    case (dlm_bl_mode_t'(lcfg.bl))
      DLM_BL_FIXED8: begin
        chop = 1'b0;
      end
      DLM_BL_PER_CMD: begin
        chop = ~link_burst_select_bit_in;
      end
      DLM_BL_FIXED4: begin
        chop = 1'b1;
      end
      default: begin
        chop = 1'b0;
      end
    endcase
    cmd.chop = chop;
    cmd.col  = link_col_in;
    rd_idx   = (lcfg.rd_lat == '0) ? '0 : lcfg.rd_lat - LW'(1);
    wr_idx   = (lcfg.wr_lat == '0) ? '0 : lcfg.wr_lat - LW'(1);
  end

  logic                     rd_pop;
  logic                     wr_pop;
  dlm_cmd_t                 rd_pay;
  dlm_cmd_t                 wr_pay;

  dlm_sched #(.DEPTH(SLOTS), .PW(PW), .IW(LW)) u_rd_sched (
    .clk_in  (link_clk_in),
    .rst_in  (lrst),
    .ins_in  (take & ~link_cmd_write_in),
    .idx_in  (rd_idx),
    .pay_in  (cmd),
    .pop_out (rd_pop),
    .pay_out (rd_pay)
  );

  dlm_sched #(.DEPTH(SLOTS), .PW(PW), .IW(LW)) u_wr_sched (
    .clk_in  (link_clk_in),
    .rst_in  (lrst),
    .ins_in  (take & link_cmd_write_in),
    .idx_in  (wr_idx),
    .pay_in  (cmd),
    .pop_out (wr_pop),
    .pay_out (wr_pay)
  );

  ////////////////////////////////////////////////////////////////////////
  // Link domain: burst engine

  dlm_state_t               st_q;
  dlm_state_t               st_d;
  logic [2:0]               beat_q;
  logic [2:0]               beat_d;
  logic [2:0]               last_q;
  logic [2:0]               last_d;
  logic [`DLM_COL_W-1:0]    col_q;
  logic [`DLM_COL_W-1:0]    col_d;
  logic [`DLM_COL_W-1:0]    addr;

  // A new start during a burst restarts the engine seamlessly
  always_comb begin
    st_d   = st_q;
    beat_d = beat_q;
    last_d = last_q;
    col_d  = col_q;
    if (wr_pop) begin
      st_d   = DLM_ST_WRITE;
      beat_d = 3'h0;
      last_d = wr_pay.chop ? `DLM_BEATS_CHOP : `DLM_BEATS_FULL;
      col_d  = wr_pay.col;
    end else if (rd_pop) begin
      st_d   = DLM_ST_READ;
      beat_d = 3'h0;
      last_d = rd_pay.chop ? `DLM_BEATS_CHOP : `DLM_BEATS_FULL;
      col_d  = rd_pay.col;
    end else begin
      case (st_q)
        DLM_ST_IDLE: begin
          st_d = DLM_ST_IDLE;
        end
        DLM_ST_READ, DLM_ST_WRITE: begin
          if (beat_q == last_q) begin
            st_d = DLM_ST_IDLE;
          end else begin
            beat_d = beat_q + 3'h1;
          end
        end
        default: begin
          st_d = DLM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      st_q   <= DLM_ST_IDLE;
      beat_q <= 3'h0;
      last_q <= 3'h0;
      col_q  <= '0;
    end else begin
      st_q   <= st_d;
      beat_q <= beat_d;
      last_q <= last_d;
      col_q  <= col_d;
    end
  end

  // Sequential order within the aligned group of eight columns
  assign addr = {col_d[`DLM_COL_W-1:3], col_d[2:0] + beat_d};

  ////////////////////////////////////////////////////////////////////////
  // Link domain: storage and byte lanes

  logic [DW-1:0]            mem_q [DEPTH];
  logic                     wr_beat;
  logic                     rd_beat;

  assign wr_beat = (st_d == DLM_ST_WRITE);
  assign rd_beat = (st_d == DLM_ST_READ);

  // Beat data and mask pin are taken on the same edge
  always_ff @(posedge link_clk_in) begin
    if (wr_beat) begin
      for (int l = 0; l < NL; l++) begin
        if ((DW <= 16) && lcfg.dbi_en) begin
          mem_q[addr][l*8 +: 8] <= link_write_mask_pin_in[l] ?
                                   link_dq_in[l*8 +: 8] : ~link_dq_in[l*8 +: 8];
        end else if ((DW == 8) && lcfg.tdqs_en) begin
          mem_q[addr][l*8 +: 8] <= link_dq_in[l*8 +: 8];
        end else if (link_write_mask_pin_in[l]) begin
          mem_q[addr][l*8 +: 8] <= link_dq_in[l*8 +: 8];
        end
      end
    end
  end

  // Reads never look at the mask pin
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      link_dq_out       <= '0;
      link_dq_oe_out    <= 1'b0;
      link_rd_valid_out <= 1'b0;
    end else if (rd_beat) begin
      link_dq_out       <= mem_q[addr];
      link_dq_oe_out    <= 1'b1;
      link_rd_valid_out <= 1'b1;
    end else begin
      link_dq_out       <= '0;
      link_dq_oe_out    <= 1'b0;
      link_rd_valid_out <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_d != DLM_ST_IDLE) | (|cs_hist_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: termination, fixed one-edge path not touched by CAL

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      link_on_die_termination_out <= 1'b0;
    end else begin
      link_on_die_termination_out <= link_on_die_termination_in;
    end
  end

endmodule : dlm_top
`default_nettype wire

//--- verilog/dlm_sched_unused_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- bench/dlm_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dlm_top_properties #(
  parameter int DW = 16
) (
  input wire logic          clock_in,
  input wire logic          sys_rst_in,
  input wire logic [7:0]    reg_addr_in,
  input wire logic [31:0]   reg_wdata_in,
  input wire logic          reg_wr_in,
  input wire logic          reg_rd_in,
  input wire logic [31:0]   reg_rdata_out,
  input wire logic          link_clk_in,
  input wire logic          link_cs_n_in,
  input wire logic          link_on_die_termination_in,
  input wire logic [DW-1:0] link_dq_out,
  input wire logic          link_dq_oe_out,
  input wire logic          link_rd_valid_out,
  input wire logic          link_on_die_termination_out
);
  logic [31:0] m0_q, m1_q, m5_q;
  logic [6:0]  add_lat, rd_lat, wr_lat, rd_wait, cnt_q;
  logic [2:0]  age_q;
  logic        st_q;
  // Shadow of the mode registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      m0_q <= 32'h0000_0958;
      m1_q <= 32'h0;
      m5_q <= 32'h0;
      st_q <= 1'b0;
    end else begin
      st_q <= reg_rd_in && reg_addr_in == 8'h0c;
      if (reg_wr_in && reg_addr_in == 8'h00) m0_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h04) m1_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h08) m5_q <= reg_wdata_in;
    end
  end
  always_comb begin
    add_lat = (m1_q[4:3] == 2'h1) ? 7'(m0_q[7:3]) - 7'h1 :
              (m1_q[4:3] == 2'h2) ? 7'(m0_q[7:3]) - 7'h2 : 7'h0;
    rd_lat  = 7'(m0_q[7:3]) + add_lat + 7'(m5_q[2:0]);
    wr_lat  = 7'(m0_q[12:8]) + add_lat + 7'(m5_q[2:0]);
    rd_wait = rd_lat + 7'(m1_q[14:12]);
  end
  // Link edges since chip select, and since reset
  always_ff @(posedge link_clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= 7'h7f;
      age_q <= 3'h0;
    end else begin
      if (!link_cs_n_in) cnt_q <= 7'h0;
      else if (cnt_q != 7'h7f) cnt_q <= cnt_q + 7'h1;
      if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_status_sum: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st_q |-> reg_rdata_out[6:0] == rd_lat && reg_rdata_out[14:8] == wr_lat)
    else $error("status latency fields wrong");
  a_rdata_pulse: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its cycle");
  a_read_lat: assert property (
    @(posedge link_clk_in) disable iff (sys_rst_in)
    $rose(link_rd_valid_out) |-> cnt_q == rd_wait)
    else $error("read data at wrong latency");
  a_fixed8_len: assert property (
    @(posedge link_clk_in) disable iff (sys_rst_in)
    $rose(link_rd_valid_out) && m0_q[1:0] == 2'h0 |-> link_rd_valid_out[*8] ##1 !link_rd_valid_out)
    else $error("fixed burst not eight beats");
  a_fixed4_len: assert property (
    @(posedge link_clk_in) disable iff (sys_rst_in)
    $rose(link_rd_valid_out) && m0_q[1:0] == 2'h2 |-> link_rd_valid_out[*4] ##1 !link_rd_valid_out)
    else $error("chopped burst not four beats");
  a_term_delay: assert property (
    @(posedge link_clk_in) disable iff (sys_rst_in)
    age_q == 3'h7 |-> link_on_die_termination_out == $past(link_on_die_termination_in))
    else $error("termination delay wrong");
  a_oe_valid: assert property (
    @(posedge link_clk_in) disable iff (sys_rst_in)
    link_dq_oe_out == link_rd_valid_out)
    else $error("drive enable apart from valid");
  a_dq_idle: assert property (
    @(posedge link_clk_in) disable iff (sys_rst_in)
    !link_rd_valid_out |-> link_dq_out == '0)
    else $error("data driven while idle");
  c_fixed8: cover property (@(posedge link_clk_in) $rose(link_rd_valid_out) && m0_q[1:0] == 2'h0);
  c_fixed4: cover property (@(posedge link_clk_in) $rose(link_rd_valid_out) && m0_q[1:0] == 2'h2);
  c_status: cover property (@(posedge clock_in) st_q);
endmodule : dlm_top_properties
bind dlm_top dlm_top_properties #(.DW(DW)) i_dlm_top_properties (.clock_in, .sys_rst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .link_clk_in,
  .link_cs_n_in, .link_on_die_termination_in, .link_dq_out, .link_dq_oe_out,
  .link_rd_valid_out, .link_on_die_termination_out);
`default_nettype wire

//--- bench/dlm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dlm_host_model (
  input  wire logic        link_clk_in,
  output var  logic        cs_n_out,
  output var  logic        wr_out,
  output var  logic        bsb_out,
  output var  logic [5:0]  col_out,
  output var  logic [15:0] dq_out,
  output var  logic [1:0]  mask_out,
  output var  logic        term_out
);
  logic [2:0] tick_q = 3'h0;
  initial begin
    cs_n_out = 1'b1;
    wr_out   = 1'b0;
    bsb_out  = 1'b0;
    col_out  = 6'h00;
    dq_out   = 16'h0000;
    mask_out = 2'h3;
    term_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Termination on its own schedule, blind to command latency mode
  always @(posedge link_clk_in) begin
    tick_q  <= tick_q + 3'h1;
    term_out <= tick_q[1];
  end
  // Select, then fields at the command edge, then inverted
  task automatic cmd(input logic w, input logic b, input logic [5:0] c, input int cal);
    @(posedge link_clk_in);
    cs_n_out <= 1'b0;
    for (int i = 0; i <= cal; i++) begin
      if (i == cal) begin
        wr_out  <= w;
        bsb_out <= b;
        col_out <= c;
      end
      @(posedge link_clk_in);
      cs_n_out <= 1'b1;
    end
    wr_out  <= ~w;
    bsb_out <= ~b;
    col_out <= ~c;
  endtask : cmd
  // Eight beats; mask pattern applied on beat one only
  // One-cycle preamble only, so the lowest write CAS latency stays legal
  task automatic wdata(input int wr_lat, input logic [15:0] base, input logic [1:0] mk);
    repeat (wr_lat - 1) @(posedge link_clk_in);
    for (int k = 0; k < 8; k++) begin
      dq_out   <= base + 16'(k);
      mask_out <= (k == 1) ? mk : 2'h3;
      @(posedge link_clk_in);
    end
    dq_out   <= ~(base + 16'h7);
    mask_out <= 2'h0;
  endtask : wdata
endmodule : dlm_host_model
`default_nettype wire

//--- bench/dlm_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dlm_top_tb_top;
  import dlm_pkg::*;
  logic        clk = 1'b0, lclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        cs_n, cw, bsb, term_i, oe, rv, term_o;
  logic [5:0]  col;
  logic [15:0] dq_i, dq_o, em [64];
  logic [1:0]  mask;
  int          num_errors = 0, checks_done = 0, cyc = 0;
  logic [71:0] rows [5] = '{{8'h04, 32'h8, 32'h1315}, {8'h08, 32'h4, 32'h1719},
    {8'h04, 32'h0, 32'h0d0f}, {8'h10, 32'hffff, 32'h0d0f}, {8'h0c, 32'hffff_ffff, 32'h0d0f}};
  initial forever #50 clk = ~clk;
  initial begin
    #3.7;
    forever #7.5 lclk = ~lclk;
  end
  dlm_top i_dlm_top (.clock_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .link_clk_in(lclk), .link_cs_n_in(cs_n), .link_cmd_write_in(cw),
    .link_burst_select_bit_in(bsb), .link_col_in(col), .link_dq_in(dq_i),
    .link_write_mask_pin_in(mask), .link_on_die_termination_in(term_i),
    .link_dq_out(dq_o), .link_dq_oe_out(oe), .link_rd_valid_out(rv),
    .link_on_die_termination_out(term_o));
  dlm_host_model i_dlm_host_model (.link_clk_in(lclk), .cs_n_out(cs_n), .wr_out(cw),
    .bsb_out(bsb), .col_out(col), .dq_out(dq_i), .mask_out(mask), .term_out(term_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask : rreg
  task automatic wburst(input logic b, input logic [5:0] c, input int cal, input int wr_lat,
                        input int n, input logic [15:0] base, input logic [1:0] mk,
                        input logic inv);
    logic [15:0] d;
    logic [1:0]  p;
    logic [5:0]  i;
    i_dlm_host_model.cmd(1'b1, b, c, cal);
    i_dlm_host_model.wdata(wr_lat, base, mk);
    for (int k = 0; k < n; k++) begin
      d = base + 16'(k);
      p = (k == 1) ? mk : 2'h3;
      i = {c[5:3], c[2:0] + 3'(k)};
      for (int l = 0; l < 2; l++)
        if (inv && !p[l]) em[i][l*8+:8] = ~d[l*8+:8];
        else if (inv || p[l]) em[i][l*8+:8] = d[l*8+:8];
    end
  endtask : wburst
  task automatic rburst(input logic b, input logic [5:0] c, input int cal, input int lat,
                        input int n);
    int t;
    t = 0;
    i_dlm_host_model.cmd(1'b0, b, c, cal);
    while (rv !== 1'b1 && t < 100) begin
      @(posedge lclk);
      #1 t++;
    end
    chk(t, lat);
    for (int k = 0; k < n; k++) begin
      chk(32'({rv, dq_o}), 32'({1'b1, em[{c[5:3], c[2:0] + 3'(k)}]}));
      @(posedge lclk);
      #1;
    end
    chk(32'(rv), 32'h0);
  endtask : rburst
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 5; n++) begin
      wreg(rows[n][71:64], rows[n][63:32]);
      rreg(8'h0c, q);
      chk(q, rows[n][31:0]);
    end
    rreg(8'h10, q);
    chk(q, 32'h0);
    wburst(1'b1, 6'h08, 0, 13, 8, 16'h1100, 2'h3, 1'b0);
    rburst(1'b1, 6'h08, 0, 15, 8);
    wreg(8'h00, 32'h959);
    wburst(1'b0, 6'h0a, 0, 13, 4, 16'h2200, 2'h1, 1'b0);
    rburst(1'b1, 6'h08, 0, 15, 8);
    rburst(1'b0, 6'h0e, 0, 15, 4);
    wreg(8'h04, 32'h8);
    wburst(1'b1, 6'h10, 0, 23, 8, 16'h3300, 2'h3, 1'b0);
    rburst(1'b1, 6'h10, 0, 25, 8);
    wreg(8'h00, 32'h95a);
    rburst(1'b1, 6'h10, 0, 25, 4);
    wreg(8'h08, 32'h804);
    wburst(1'b1, 6'h10, 0, 23, 4, 16'h4400, 2'h2, 1'b1);
    rburst(1'b1, 6'h10, 0, 25, 4);
    wreg(8'h04, 32'h3008);
    rburst(1'b1, 6'h10, 3, 25, 4);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h00, q);
    chk(q, 32'h958);
    rreg(8'h0c, q);
    chk(q, 32'h090b);
    tally_and_finish();
  end
endmodule : dlm_top_tb_top
`default_nettype wire
